// File: mr_access_pkg.sv
`default_nettype none
package mr_access_pkg;
  localparam int MR_ADDR_W = 6;
  localparam int MR_DATA_W = 8;
  localparam logic [5:0] MODE_REGISTER_THIRTEEN = 6'h0d;
  localparam int BOOST_ENABLE_BIT = 3;
  localparam logic [7:0] REG_THIRTEEN_RESET = 8'h00;
  localparam int REF_CLK_MHZ = 125;
  // Settling times in ns, converted to ref_clk cycles (shortest time: round down)
  localparam int BOOST_ENABLE_SETTLE_NS = 200;
  localparam int BOOST_DISABLE_SETTLE_NS = 100;
  localparam int BOOST_ENABLE_CYC = (BOOST_ENABLE_SETTLE_NS * REF_CLK_MHZ) / 1000;
  localparam int BOOST_DISABLE_CYC = (BOOST_DISABLE_SETTLE_NS * REF_CLK_MHZ) / 1000;
  localparam int SETTLE_W = 8;
  // Mode registers that software may only read
  localparam logic [63:0] MR_READ_ONLY_MASK = 64'h0000_0000_0000_0119;
  typedef enum logic [2:0]
  {
    BANK_IDLE = 3'b001,
    MODE_READING = 3'b010,
    MODE_WRITING = 3'b100
  } mr_state_t;
endpackage : mr_access_pkg
`default_nettype wire

// File: pulse_crossing.sv
`timescale 1ns/1ns
`default_nettype none
// Toggle-based event crossing from the link clock into ref_clk
module pulse_crossing
(
  // Source side
  input wire logic src_clk,
  input wire logic src_rst_b,
  input wire logic src_pulse,
  // Destination side
  input wire logic dst_clk,
  input wire logic dst_rst_b,
  output logic dst_pulse
);
  logic src_toggle;
  logic sync1;
  logic sync2;
  logic sync3;

  always_ff @(posedge src_clk or negedge src_rst_b)
  begin
    if (!src_rst_b)
      src_toggle <= 1'b0;
    else if (src_pulse)
      src_toggle <= ~src_toggle;
  end

  always_ff @(posedge dst_clk or negedge dst_rst_b)
  begin
    if (!dst_rst_b)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end
    else
    begin
      sync1 <= src_toggle;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign dst_pulse = sync2 ^ sync3;
endmodule : pulse_crossing
`default_nettype wire

// File: mode_register_access_timing.sv
// Functional notes
// - Mode reads and writes are accepted with banks idle or active and the bank state returns after.
// - Writing one to bit 3 of mode register 13 turns the reference current boost on.
// - Writing zero to bit 3 of mode register 13 turns the reference current boost off.
// - Reference range and value changes are accepted without the boost enabled.
// - A mode write to a read-only mode register changes no register or output, but mode_busy still pulses.
`timescale 1ns/1ns
`default_nettype none
module mode_register_access_timing
  import mr_access_pkg::*;
#(
  parameter int ADDR_W = MR_ADDR_W,
  parameter int DATA_W = MR_DATA_W
)
(
  // System
  input wire logic ref_clk,
  input wire logic rst_b,
  // Decoded command from the link, on link_clk
  input wire logic link_clk,
  input wire logic mode_write_cmd,
  input wire logic mode_read_cmd,
  input wire logic [ADDR_W-1:0] mode_addr,
  input wire logic [DATA_W-1:0] mode_data,
  // Bank state
  input wire logic banks_active,
  output logic banks_active_out,
  output logic mode_busy,
  // Reference voltage control
  output logic reference_current_boost,
  output logic boost_settling,
  output logic vref_update,
  output logic [DATA_W-1:0] mode_register_thirteen
);
  logic rst_s1;
  logic rst_s2;
  logic link_rst1;
  logic link_rst2;
  logic wr_cap;
  logic rd_cap;
  logic [ADDR_W-1:0] addr_cap;
  logic [DATA_W-1:0] data_cap;
  logic wr_pulse;
  logic rd_pulse;
  logic ba_s1;
  logic ba_s2;
  logic wr_ok;
  logic [SETTLE_W-1:0] settle_cnt;
  mr_state_t state;

  // Reset release, one copy per domain
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link_rst1 <= 1'b0;
      link_rst2 <= 1'b0;
    end
    else
    begin
      link_rst1 <= 1'b1;
      link_rst2 <= link_rst1;
    end
  end

  // Address and data held stable across the crossing; the controller's spacing
  // keeps two commands far enough apart for the pulse to land first.
  always_ff @(posedge link_clk or negedge link_rst2)
  begin
    if (!link_rst2)
    begin
      wr_cap <= 1'b0;
      rd_cap <= 1'b0;
      addr_cap <= '0;
      data_cap <= '0;
    end
    else
    begin
      wr_cap <= mode_write_cmd;
      rd_cap <= mode_read_cmd;
      if (mode_write_cmd)
      begin
        addr_cap <= mode_addr;
        data_cap <= mode_data;
      end
    end
  end

  pulse_crossing u_wr_cross
  (
    .src_clk(link_clk),
    .src_rst_b(link_rst2),
    .src_pulse(wr_cap),
    .dst_clk(ref_clk),
    .dst_rst_b(rst_s2),
    .dst_pulse(wr_pulse)
  );

  pulse_crossing u_rd_cross
  (
    .src_clk(link_clk),
    .src_rst_b(link_rst2),
    .src_pulse(rd_cap),
    .dst_clk(ref_clk),
    .dst_rst_b(rst_s2),
    .dst_pulse(rd_pulse)
  );

  always_ff @(posedge ref_clk or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      ba_s1 <= 1'b0;
      ba_s2 <= 1'b0;
    end
    else
    begin
      ba_s1 <= banks_active;
      ba_s2 <= ba_s1;
    end
  end

  // Read-only targets are dropped here so nothing downstream changes
  assign wr_ok = wr_pulse && !MR_READ_ONLY_MASK[addr_cap];

  // Access state: the bank state is not touched by a mode access
  always_ff @(posedge ref_clk or negedge rst_s2)
  begin
    if (!rst_s2)
      state <= BANK_IDLE;
    else
    begin
      case (state)
        BANK_IDLE:
        begin
          if (rd_pulse)
            state <= MODE_READING;
          else if (wr_pulse)
            state <= MODE_WRITING;
        end
        MODE_READING:
          state <= BANK_IDLE;
        MODE_WRITING:
          state <= BANK_IDLE;
        default:
          state <= BANK_IDLE;
      endcase
    end
  end

  assign mode_busy = (state != BANK_IDLE);

  always_ff @(posedge ref_clk or negedge rst_s2)
  begin
    if (!rst_s2)
      banks_active_out <= 1'b0;
    else
      banks_active_out <= ba_s2;
  end

  always_ff @(posedge ref_clk or negedge rst_s2)
  begin
    if (!rst_s2)
      mode_register_thirteen <= REG_THIRTEEN_RESET;
    else if (wr_ok && addr_cap == MODE_REGISTER_THIRTEEN)
      mode_register_thirteen <= data_cap;
  end

  assign reference_current_boost = mode_register_thirteen[BOOST_ENABLE_BIT];

  // Settling window after a boost change; only deselects expected meanwhile
  always_ff @(posedge ref_clk or negedge rst_s2)
  begin
    if (!rst_s2)
      settle_cnt <= '0;
    else if (wr_ok && addr_cap == MODE_REGISTER_THIRTEEN
             && data_cap[BOOST_ENABLE_BIT] != reference_current_boost)
    begin
      if (data_cap[BOOST_ENABLE_BIT])
        settle_cnt <= SETTLE_W'(BOOST_ENABLE_CYC);
      else
        settle_cnt <= SETTLE_W'(BOOST_DISABLE_CYC);
    end
    else if (settle_cnt != '0)
      settle_cnt <= settle_cnt - 1'b1;
  end

  assign boost_settling = (settle_cnt != '0);

  // Reference updates do not wait on the boost
  always_ff @(posedge ref_clk or negedge rst_s2)
  begin
    if (!rst_s2)
      vref_update <= 1'b0;
    else
      vref_update <= wr_ok && addr_cap != MODE_REGISTER_THIRTEEN;
  end

  a_boost_follows_bit: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    $past(wr_ok && addr_cap == MODE_REGISTER_THIRTEEN) |->
    reference_current_boost == $past(data_cap[BOOST_ENABLE_BIT]))
    else $error("boost does not follow written bit");

  a_boost_off: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    $fell(reference_current_boost) |-> settle_cnt == SETTLE_W'(BOOST_DISABLE_CYC))
    else $error("disable settle not loaded");

  a_readonly_ignored: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    (wr_pulse && MR_READ_ONLY_MASK[addr_cap]) |=> $stable(mode_register_thirteen))
    else $error("read-only write changed state");

  a_access_returns: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    (state != BANK_IDLE) |=> state == BANK_IDLE)
    else $error("access did not return to bank state");

  a_vref_no_boost: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    (wr_ok && addr_cap != MODE_REGISTER_THIRTEEN) |=> vref_update)
    else $error("reference update blocked");
endmodule : mode_register_access_timing
`default_nettype wire

// File: ctl_model.sv
`timescale 1ns/1ns
`default_nettype none
module ctl_model
(
  // Link side
  input wire logic link_clk,
  output logic mode_write_cmd,
  output logic mode_read_cmd,
  output logic [5:0] mode_addr,
  output logic [7:0] mode_data
);
  initial
  begin
    mode_write_cmd = 1'b0;
    mode_read_cmd = 1'b0;
    mode_addr = 6'h15;
    mode_data = 8'h5a;
  end
  task automatic issue(input logic wr, input logic [5:0] a, input logic [7:0] d);
  begin
    @(posedge link_clk);
    #1;
    mode_write_cmd = wr;
    mode_read_cmd = !wr;
    mode_addr = a;
    mode_data = d;
    @(posedge link_clk);
    #1;
    mode_write_cmd = 1'b0;
    mode_read_cmd = 1'b0;
    // Stale fields are inverted so nothing can lean on them
    mode_addr = ~a;
    mode_data = ~d;
    // Only deselects for 360 ns: covers every spacing and both settle times
    repeat (12) @(posedge link_clk);
  end
  endtask : issue
endmodule : ctl_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import mr_access_pkg::*;
  logic ref_clk, link_clk, rst_b, banks_active;
  logic mwr, mrd, bout, busy, boost, settling, vupd;
  logic [5:0] addr;
  logic [7:0] data, reg13;
  int bad_count, n_compared, cycles, n_set, n_vu, n_busy;
  ctl_model i_ctl (.link_clk(link_clk), .mode_write_cmd(mwr), .mode_read_cmd(mrd),
    .mode_addr(addr), .mode_data(data));
  mode_register_access_timing i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .link_clk(link_clk), .mode_write_cmd(mwr), .mode_read_cmd(mrd), .mode_addr(addr),
    .mode_data(data), .banks_active(banks_active), .banks_active_out(bout),
    .mode_busy(busy), .reference_current_boost(boost), .boost_settling(settling),
    .vref_update(vupd), .mode_register_thirteen(reg13));
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end
  // Counted mid-cycle so every sample sees settled outputs
  always @(negedge ref_clk)
  begin
    cycles++;
    n_set += int'(settling === 1'b1);
    n_vu += int'(vupd === 1'b1);
    n_busy += int'(busy === 1'b1);
    if (cycles == 20000)
    begin
      bad_count++;
      summarize();
    end
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic run(input logic wr, input logic [5:0] a, input logic [7:0] d);
    n_set = 0;
    n_vu = 0;
    n_busy = 0;
    i_ctl.issue(wr, a, d);
  endtask : run
  task automatic t_reset;
    check("boost", 8'h00, {7'h0, boost});
    check("reg13", 8'h00, reg13);
    check("settling", 8'h00, {7'h0, settling});
    check("busy", 8'h00, {7'h0, busy});
    check("vref_upd", 8'h00, {7'h0, vupd});
    check("banks_out", 8'h00, {7'h0, bout});
    $display("test reset done");
  endtask : t_reset
  task automatic t_boost_on;
    @(posedge ref_clk);
    #1;
    banks_active = 1'b1;
    run(1'b1, MODE_REGISTER_THIRTEEN, 8'h08);
    check("boost", 8'h01, {7'h0, boost});
    check("reg13", 8'h08, reg13);
    check("settle_on", 8'h01, {7'h0, n_set > 0 && n_set <= BOOST_ENABLE_CYC});
    check("settle_on_len", 8'(BOOST_ENABLE_CYC), n_set[7:0]);
    check("vref_upd", 8'h00, n_vu[7:0]);
    check("busy", 8'h01, n_busy[7:0]);
    check("banks_out", 8'h01, {7'h0, bout});
    $display("test boost_on done");
  endtask : t_boost_on
  task automatic t_boost_off;
    run(1'b1, MODE_REGISTER_THIRTEEN, 8'h00);
    check("boost", 8'h00, {7'h0, boost});
    check("settle_off", 8'h01, {7'h0, n_set > 0 && n_set <= BOOST_DISABLE_CYC});
    check("settle_off_len", 8'(BOOST_DISABLE_CYC), n_set[7:0]);
    check("banks_out", 8'h01, {7'h0, bout});
    $display("test boost_off done");
  endtask : t_boost_off
  task automatic t_read_only;
    run(1'b1, 6'h03, 8'hff);
    check("reg13", 8'h00, reg13);
    check("vref_upd", 8'h00, n_vu[7:0]);
    check("boost", 8'h00, {7'h0, boost});
    $display("test read_only done");
  endtask : t_read_only
  task automatic t_vref;
    run(1'b1, 6'h0c, 8'h4d);
    check("vref_upd", 8'h01, n_vu[7:0]);
    @(posedge ref_clk);
    #1;
    banks_active = 1'b0;
    run(1'b0, 6'h0d, 8'h00);
    check("busy", 8'h01, n_busy[7:0]);
    check("banks_out", 8'h00, {7'h0, bout});
    check("reg13", 8'h00, reg13);
    $display("test vref done");
  endtask : t_vref
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  initial
  begin
    rst_b = 1'b0;
    banks_active = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge link_clk);
    t_reset();
    t_boost_on();
    t_boost_off();
    t_read_only();
    t_vref();
    summarize();
  end
endmodule : testbench
`default_nettype wire
